// File: strap_config_and_port_select.sv
/*
 * strap configuration loader and serial port selection for a four channel
 * clock fanout. drives an external level converter one strap at a time.
 * assumes all inputs synchronous to i_clock; i_reset_n is the power-on reset.
 */
// Function
// - mode select high puts the device in strap mode with the i2c serial port selected
// - straps 0..3 set own channel divider: 1,2,3,4,5,6,8,16
// - strap 4 selects channel 0/1 output kind pair from eight levels
// - strap 5 selects channel 2/3 kinds with the same pair encoding
// - strap mode caps divider at 16 and disables phase offset control
// - settings apply after every strap scanned; scan on reset or sync toggle
// - later strap changes ignored until sync is toggled by outside party
// - in strap mode an unterminated hstl channel splits into two antiphase single ended outputs
// - mode select level chooses between spi and i2c serial port
// - i2c slave address high five bits are fixed at 11011
// - i2c address low bits: strap 4 is bit 1, strap 5 is bit 0
// - spi mode keeps port configuration in its own register at offset 0
// - spi mode accepts single byte and multiple byte transfers
// - sync rising edge aligns outputs; sync low forces unmasked outputs static
// - strap mode fixes output drive current at nominal
module strap_config_and_port_select (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_strap_mode_select,
    input wire logic i_sync_n,
    input wire logic [3:0] i_sync_mask,
    input wire logic [3:0] i_termination_absent,
    input wire logic i_adc_done,
    input wire logic [strap_config_pkg::level_width-1:0] i_adc_level,
    input wire logic i_spi_config_write,
    input wire logic [7:0] i_spi_config_offset,
    input wire logic [7:0] i_spi_config_data,
    output logic o_adc_start,
    output logic [strap_config_pkg::chan_width-1:0] o_adc_channel,
    output logic o_scan_busy,
    output logic o_config_valid,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch0_div,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch1_div,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch2_div,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch3_div,
    output strap_config_pkg::output_kind_type o_ch0_type,
    output strap_config_pkg::output_kind_type o_ch1_type,
    output strap_config_pkg::output_kind_type o_ch2_type,
    output strap_config_pkg::output_kind_type o_ch3_type,
    output logic [3:0] o_ch_single_ended,
    output logic [6:0] o_i2c_address,
    output logic o_port_spi,
    output logic o_port_i2c,
    output logic [7:0] o_spi_port_config,
    output logic o_spi_multibyte_enable,
    output logic o_strap_mode,
    output logic o_phase_offset_enable,
    output logic o_drive_adjust_enable,
    output logic o_sync_align,
    output logic [3:0] o_ch_static
);
    typedef enum logic [1:0] {
        scan_idle,
        scan_issue,
        scan_wait
    } scan_phase_type;

    typedef struct packed {
        scan_phase_type phase;
        logic pending;
        logic sync_prev;
        logic [strap_config_pkg::chan_width-1:0] channel;
        logic [strap_config_pkg::codes_width-1:0] codes;
        logic load;
        logic adc_start;
        logic busy;
        logic valid;
        logic [3:0] single_ended;
        logic port_spi;
        logic port_i2c;
        logic [7:0] spi_config;
        logic multibyte;
        logic strap_mode;
        logic phase_enable;
        logic drive_enable;
        logic sync_align;
        logic [3:0] ch_static;
    } loader_state_type;

    loader_state_type state;
    loader_state_type next_state;
    logic sync_rise;
    strap_config_pkg::output_kind_type kinds [4];

    always_comb begin
        next_state = state;
        sync_rise = i_sync_n && !state.sync_prev;
        next_state.sync_prev = i_sync_n;
        next_state.load = 1'b0;
        next_state.adc_start = 1'b0;
        next_state.sync_align = sync_rise;
        next_state.ch_static = {4{!i_sync_n}} & ~i_sync_mask;
        next_state.strap_mode = i_strap_mode_select;
        next_state.phase_enable = !i_strap_mode_select;
        next_state.drive_enable = !i_strap_mode_select;
        next_state.port_i2c = i_strap_mode_select;
        next_state.port_spi = !i_strap_mode_select;
        next_state.multibyte = !i_strap_mode_select;
        // written only while the spi port is the one selected
        if (!i_strap_mode_select && i_spi_config_write &&
            i_spi_config_offset == strap_config_pkg::spi_config_offset) begin
            next_state.spi_config = i_spi_config_data;
        end
        // a channel splits only while hstl with its termination absent
        for (int k = 0; k < 4; k++) begin
            next_state.single_ended[k] = i_strap_mode_select && i_termination_absent[k] &&
                                         kinds[k] == strap_config_pkg::out_hstl;
        end
        // straps are read one at a time, lowest index first
        case (state.phase)
            scan_idle: begin
                if (state.pending && i_strap_mode_select) begin
                    next_state.pending = 1'b0;
                    next_state.channel = '0;
                    next_state.busy = 1'b1;
                    next_state.phase = scan_issue;
                end
            end
            scan_issue: begin
                next_state.adc_start = 1'b1;
                next_state.phase = scan_wait;
            end
            scan_wait: begin
                if (i_adc_done) begin
                    next_state.codes[state.channel*strap_config_pkg::level_width +:
                                     strap_config_pkg::level_width] = i_adc_level;
                    if (state.channel == strap_config_pkg::last_strap) begin
                        // apply only once every strap has been read
                        next_state.load = 1'b1;
                        next_state.valid = 1'b1;
                        next_state.busy = 1'b0;
                        next_state.phase = scan_idle;
                    end else begin
                        next_state.channel = state.channel + 3'h1;
                        next_state.phase = scan_issue;
                    end
                end
            end
            default: begin
                next_state.phase = scan_idle;
            end
        endcase
        // a sync toggle requests a fresh scan and wins over the clear above
        if (sync_rise) begin
            next_state.pending = 1'b1;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // sync_prev starts high so an idle high sync pin gives no false edge
            state <= '{
                phase: scan_idle,
                pending: 1'b1,
                sync_prev: 1'b1,
                channel: '0,
                codes: strap_config_pkg::codes_reset,
                load: 1'b0,
                adc_start: 1'b0,
                busy: 1'b0,
                valid: 1'b0,
                single_ended: 4'h0,
                port_spi: 1'b1,
                port_i2c: 1'b0,
                spi_config: strap_config_pkg::spi_config_reset,
                multibyte: 1'b1,
                strap_mode: 1'b0,
                phase_enable: 1'b1,
                drive_enable: 1'b1,
                sync_align: 1'b0,
                ch_static: 4'h0
            };
        end else if (i_enable) begin
            state <= next_state;
        end
    end

    strap_decode decode (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_enable(i_enable),
        .i_load(state.load),
        .i_codes(state.codes),
        .o_ch0_div(o_ch0_div),
        .o_ch1_div(o_ch1_div),
        .o_ch2_div(o_ch2_div),
        .o_ch3_div(o_ch3_div),
        .o_ch0_type(o_ch0_type),
        .o_ch1_type(o_ch1_type),
        .o_ch2_type(o_ch2_type),
        .o_ch3_type(o_ch3_type),
        .o_i2c_address(o_i2c_address)
    );

    // registered kinds feed the single ended flag, so it trails a load by two cycles
    assign kinds[0] = o_ch0_type;
    assign kinds[1] = o_ch1_type;
    assign kinds[2] = o_ch2_type;
    assign kinds[3] = o_ch3_type;
    assign o_adc_start = state.adc_start;
    assign o_adc_channel = state.channel;
    assign o_scan_busy = state.busy;
    assign o_config_valid = state.valid;
    assign o_ch_single_ended = state.single_ended;
    assign o_port_spi = state.port_spi;
    assign o_port_i2c = state.port_i2c;
    assign o_spi_port_config = state.spi_config;
    assign o_spi_multibyte_enable = state.multibyte;
    assign o_strap_mode = state.strap_mode;
    assign o_phase_offset_enable = state.phase_enable;
    assign o_drive_adjust_enable = state.drive_enable;
    assign o_sync_align = state.sync_align;
    assign o_ch_static = state.ch_static;
endmodule : strap_config_and_port_select

// File: strap_config_pkg.sv
/*
 * constants and types shared by the strap configuration loader and its decoder.
 * assumes nothing of its surroundings beyond a compile order that puts it first.
 */
package strap_config_pkg;
    localparam int strap_count = 6;
    localparam int level_width = 3;
    localparam int ratio_width = 5;
    localparam int chan_width = 3;
    localparam logic [chan_width-1:0] last_strap = 3'h5;
    localparam logic [chan_width-1:0] type01_strap = 3'h4;
    localparam logic [chan_width-1:0] type23_strap = 3'h5;
    localparam int codes_width = strap_count * level_width;
    localparam logic [codes_width-1:0] codes_reset = 18'h00000;
    // divide ratio for scanned levels 0..7
    localparam logic [ratio_width-1:0] ratio_table [8] = '{
        5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h10};
    localparam logic [ratio_width-1:0] ratio_reset = 5'h01;
    localparam logic [ratio_width-1:0] ratio_max = 5'h10;
    // i2c slave address: fixed high part, then strap 4 bit, then strap 5 bit
    localparam logic [4:0] i2c_address_high = 5'h1B;
    localparam int pin_high_bit = 2;
    localparam logic [7:0] spi_config_reset = 8'h00;
    localparam logic [7:0] spi_config_offset = 8'h00;

    typedef enum logic [1:0] {
        out_hstl,
        out_lvds,
        out_high_z
    } output_kind_type;

    // pair encoding shared by both type straps
    function automatic output_kind_type pair_first(input logic [level_width-1:0] level);
        if (level < 3'h3) begin
            return out_hstl;
        end else if (level < 3'h6) begin
            return out_lvds;
        end
        return out_high_z;
    endfunction : pair_first

    function automatic output_kind_type pair_second(input logic [level_width-1:0] level);
        logic [level_width-1:0] rest;
        rest = level;
        if (level == 3'h6) begin
            return out_hstl;
        end else if (level == 3'h7) begin
            return out_high_z;
        end
        rest = (level >= 3'h3) ? level - 3'h3 : level;
        case (rest)
            3'h0: return out_hstl;
            3'h1: return out_lvds;
            default: return out_high_z;
        endcase
    endfunction : pair_second
endpackage : strap_config_pkg

// File: strap_decode.sv
/*
 * registered decoder: turns six latched strap levels into divide ratios,
 * output kinds and the i2c address. assumes load pulses only after a full scan.
 */
module strap_decode (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_load,
    input wire logic [strap_config_pkg::codes_width-1:0] i_codes,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch0_div,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch1_div,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch2_div,
    output logic [strap_config_pkg::ratio_width-1:0] o_ch3_div,
    output strap_config_pkg::output_kind_type o_ch0_type,
    output strap_config_pkg::output_kind_type o_ch1_type,
    output strap_config_pkg::output_kind_type o_ch2_type,
    output strap_config_pkg::output_kind_type o_ch3_type,
    output logic [6:0] o_i2c_address
);
    typedef struct packed {
        logic [strap_config_pkg::ratio_width-1:0] div0;
        logic [strap_config_pkg::ratio_width-1:0] div1;
        logic [strap_config_pkg::ratio_width-1:0] div2;
        logic [strap_config_pkg::ratio_width-1:0] div3;
        strap_config_pkg::output_kind_type kind0;
        strap_config_pkg::output_kind_type kind1;
        strap_config_pkg::output_kind_type kind2;
        strap_config_pkg::output_kind_type kind3;
        logic [6:0] address;
    } decode_state_type;

    decode_state_type state;
    decode_state_type next_state;

    function automatic logic [2:0] level_of(input logic [strap_config_pkg::codes_width-1:0] c,
                                            input int idx);
        return c[idx*strap_config_pkg::level_width +: strap_config_pkg::level_width];
    endfunction : level_of

    always_comb begin
        next_state = state;
        if (i_load) begin
            // each divider strap steers its own channel only
            next_state.div0 = strap_config_pkg::ratio_table[level_of(i_codes, 0)];
            next_state.div1 = strap_config_pkg::ratio_table[level_of(i_codes, 1)];
            next_state.div2 = strap_config_pkg::ratio_table[level_of(i_codes, 2)];
            next_state.div3 = strap_config_pkg::ratio_table[level_of(i_codes, 3)];
            next_state.kind0 = strap_config_pkg::pair_first(level_of(i_codes, 4));
            next_state.kind1 = strap_config_pkg::pair_second(level_of(i_codes, 4));
            next_state.kind2 = strap_config_pkg::pair_first(level_of(i_codes, 5));
            next_state.kind3 = strap_config_pkg::pair_second(level_of(i_codes, 5));
            // pulled to supply reads as a high pin
            next_state.address = {strap_config_pkg::i2c_address_high,
                i_codes[strap_config_pkg::type01_strap * strap_config_pkg::level_width
                        + strap_config_pkg::pin_high_bit],
                i_codes[strap_config_pkg::type23_strap * strap_config_pkg::level_width
                        + strap_config_pkg::pin_high_bit]};
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= '{strap_config_pkg::ratio_reset, strap_config_pkg::ratio_reset,
                       strap_config_pkg::ratio_reset, strap_config_pkg::ratio_reset,
                       strap_config_pkg::out_hstl, strap_config_pkg::out_hstl,
                       strap_config_pkg::out_hstl, strap_config_pkg::out_hstl,
                       {strap_config_pkg::i2c_address_high, 2'h0}};
        end else if (i_enable) begin
            state <= next_state;
        end
    end

    assign o_ch0_div = state.div0;
    assign o_ch1_div = state.div1;
    assign o_ch2_div = state.div2;
    assign o_ch3_div = state.div3;
    assign o_ch0_type = state.kind0;
    assign o_ch1_type = state.kind1;
    assign o_ch2_type = state.kind2;
    assign o_ch3_type = state.kind3;
    assign o_i2c_address = state.address;
endmodule : strap_decode

// File: strap_adc_model.sv
/*
 * level converter and strap resistors on the far side of the loader.
 * assumes the loader raises its start pulse on a rising clock edge.
 */
module strap_adc_model (
    input wire logic i_clock,
    input wire logic i_start,
    input wire logic [2:0] i_channel,
    input wire logic [17:0] i_levels,
    input wire logic i_slow,
    output logic o_done,
    output logic [2:0] o_level
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_done = 1'b0;
        o_level = 3'h5;
        forever begin
            @(posedge i_clock);
            if (i_start === 1'b1) begin
                repeat (i_slow ? 6 : 1) @(posedge i_clock);
                #1;
                o_done = 1'b1;
                // each pin reports its own level; a grounded pin reads as level 0
                o_level = i_levels[3*i_channel +: 3];
                @(posedge i_clock);
                #1;
                o_done = 1'b0;
                // result no longer held: show the inverse
                o_level = ~o_level;
            end
        end
    end
endmodule : strap_adc_model

// File: strap_config_and_port_select_properties.sv
/*
 * concurrent checks on the ports of the strap loader.
 * assumes one clock domain and a steady high clock enable.
 */
module strap_config_props (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_enable,
    input wire logic i_strap_mode_select,
    input wire logic i_sync_n,
    input wire logic [3:0] i_sync_mask,
    input wire logic i_spi_config_write,
    input wire logic [7:0] i_spi_config_offset,
    input wire logic o_adc_start,
    input wire logic o_scan_busy,
    input wire logic o_config_valid,
    input wire logic [4:0] o_ch0_div,
    input wire logic [4:0] o_ch1_div,
    input wire logic [4:0] o_ch2_div,
    input wire logic [4:0] o_ch3_div,
    input wire logic [6:0] o_i2c_address,
    input wire logic o_port_spi,
    input wire logic o_port_i2c,
    input wire logic [7:0] o_spi_port_config,
    input wire logic o_spi_multibyte_enable,
    input wire logic o_strap_mode,
    input wire logic o_phase_offset_enable,
    input wire logic o_drive_adjust_enable,
    input wire logic o_sync_align,
    input wire logic [3:0] o_ch_static
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_reset_n);
    conv_start_a: assert property ($rose(o_scan_busy) |=> o_adc_start)
        else $error("scan began without a conversion start");
    start_pulse_a: assert property (o_adc_start |=> !o_adc_start)
        else $error("conversion start longer than one cycle");
    scan_valid_a: assert property ($fell(o_scan_busy) |-> o_config_valid)
        else $error("scan ended without valid settings");
    port_follow_a: assert property (i_enable |=>
        o_port_i2c == $past(i_strap_mode_select) && o_port_spi != o_port_i2c)
        else $error("serial port choice does not follow mode select");
    addr_high_a: assert property (o_i2c_address[6:2] == 5'h1B)
        else $error("fixed address bits wrong");
    div_cap_a: assert property (o_ch0_div <= 5'h10 && o_ch1_div <= 5'h10 &&
        o_ch2_div <= 5'h10 && o_ch3_div <= 5'h10)
        else $error("divider above sixteen");
    strap_fixed_a: assert property (o_strap_mode |->
        !o_phase_offset_enable && !o_drive_adjust_enable)
        else $error("adjustments enabled in strap mode");
    multi_byte_a: assert property (o_spi_multibyte_enable == o_port_spi)
        else $error("multibyte enable disagrees with port");
    spi_hold_a: assert property (
        !(i_spi_config_write && i_spi_config_offset == 8'h00 && !i_strap_mode_select)
        |=> $stable(o_spi_port_config))
        else $error("spi config changed without a write");
    static_out_a: assert property (i_enable |=>
        o_ch_static == (~{4{$past(i_sync_n)}} & ~$past(i_sync_mask)))
        else $error("static outputs do not follow sync");
    sync_align_a: assert property ($rose(i_sync_n) |=> o_sync_align)
        else $error("no alignment after sync release");
    hold_cfg_a: assert property (!$fell(o_scan_busy) |=>
        $stable({o_ch0_div, o_ch1_div, o_ch2_div, o_ch3_div, o_i2c_address}))
        else $error("settings changed outside a scan completion");
    scan_done_c: cover property ($fell(o_scan_busy));
    align_c: cover property (o_sync_align);
    spi_write_c: cover property ($changed(o_spi_port_config));
endmodule : strap_config_props
bind strap_config_and_port_select strap_config_props u_props (.i_clock(i_clock),
    .i_reset_n(i_reset_n), .i_enable(i_enable), .i_strap_mode_select(i_strap_mode_select),
    .i_sync_n(i_sync_n), .i_sync_mask(i_sync_mask), .i_spi_config_write(i_spi_config_write),
    .i_spi_config_offset(i_spi_config_offset), .o_adc_start(o_adc_start),
    .o_scan_busy(o_scan_busy), .o_config_valid(o_config_valid), .o_ch0_div(o_ch0_div),
    .o_ch1_div(o_ch1_div), .o_ch2_div(o_ch2_div), .o_ch3_div(o_ch3_div),
    .o_i2c_address(o_i2c_address), .o_port_spi(o_port_spi), .o_port_i2c(o_port_i2c),
    .o_spi_port_config(o_spi_port_config), .o_spi_multibyte_enable(o_spi_multibyte_enable),
    .o_strap_mode(o_strap_mode), .o_phase_offset_enable(o_phase_offset_enable),
    .o_drive_adjust_enable(o_drive_adjust_enable), .o_sync_align(o_sync_align),
    .o_ch_static(o_ch_static));

// File: strap_config_and_port_select_tb_top.sv
/*
 * self-checking bench for the strap loader with a level converter model.
 * assumes the design package is compiled first and the clock enable stays high.
 */
module strap_config_and_port_select_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clock, i_reset_n = 1'b0, mode = 1'b1, sync_n = 1'b1, wr = 1'b0, done, slow = 1'b0;
    logic [3:0] mask = 4'h0, term = 4'h0, se, st;
    logic [2:0] level, chan;
    logic [7:0] offs = 8'h00, data = 8'h00, d;
    logic [17:0] straps = 18'h0A3D1, old;
    logic [31:0] rnd = 32'h00016356;
    logic start, busy, valid, p_spi, p_i2c, multi, smode, ph_en, dr_en, align;
    logic [4:0] dv0, dv1, dv2, dv3;
    logic [6:0] addr;
    logic [7:0] cfg;
    strap_config_pkg::output_kind_type ty0, ty1, ty2, ty3;
    int error_cnt = 0, cmp_count = 0;
    strap_config_and_port_select uut (.i_clock(i_clock), .i_reset_n(i_reset_n),
        .i_enable(1'b1), .i_strap_mode_select(mode), .i_sync_n(sync_n), .i_sync_mask(mask),
        .i_termination_absent(term), .i_adc_done(done), .i_adc_level(level),
        .i_spi_config_write(wr), .i_spi_config_offset(offs), .i_spi_config_data(data),
        .o_adc_start(start), .o_adc_channel(chan), .o_scan_busy(busy), .o_config_valid(valid),
        .o_ch0_div(dv0), .o_ch1_div(dv1), .o_ch2_div(dv2), .o_ch3_div(dv3), .o_ch0_type(ty0),
        .o_ch1_type(ty1), .o_ch2_type(ty2), .o_ch3_type(ty3), .o_ch_single_ended(se),
        .o_i2c_address(addr), .o_port_spi(p_spi), .o_port_i2c(p_i2c), .o_spi_port_config(cfg),
        .o_spi_multibyte_enable(multi), .o_strap_mode(smode), .o_phase_offset_enable(ph_en),
        .o_drive_adjust_enable(dr_en), .o_sync_align(align), .o_ch_static(st));
    strap_adc_model u_adc (.i_clock(i_clock), .i_start(start), .i_channel(chan),
        .i_levels(straps), .i_slow(slow), .o_done(done), .o_level(level));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task automatic step(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step
    function automatic logic [31:0] roll(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : roll
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [4:0] exp_div(input logic [2:0] v);
        return (v == 3'h7) ? 5'h10 : (v == 3'h6) ? 5'h08 : {2'h0, v} + 5'h01;
    endfunction : exp_div
    function automatic logic [1:0] exp_kind(input logic [2:0] v, input logic second);
        if (second) return (v == 3'h7) ? 2'h2 : (v == 3'h6) ? 2'h0 : 2'(v % 3'h3);
        return (v < 3'h3) ? 2'h0 : (v < 3'h6) ? 2'h1 : 2'h2;
    endfunction : exp_kind
    task automatic check_cfg(input logic [17:0] lv);
        logic [1:0] k [4];
        logic [3:0] s;
        k[0] = exp_kind(lv[14:12], 1'b0);
        k[1] = exp_kind(lv[14:12], 1'b1);
        k[2] = exp_kind(lv[17:15], 1'b0);
        k[3] = exp_kind(lv[17:15], 1'b1);
        for (int c = 0; c < 4; c++) s[c] = term[c] && k[c] == 2'h0;
        check(dv0, exp_div(lv[2:0]));
        check(dv1, exp_div(lv[5:3]));
        check(dv2, exp_div(lv[8:6]));
        check(dv3, exp_div(lv[11:9]));
        check(ty0, k[0]);
        check(ty1, k[1]);
        check(ty2, k[2]);
        check(ty3, k[3]);
        check(addr, {5'h1B, lv[14], lv[17]});
        check(se, s);
        check(valid, 1'b1);
    endtask : check_cfg
    task automatic run_scan(input logic [17:0] lv);
        int k;
        k = 0;
        while (busy !== 1'b1 && k < 20) begin
            step(1);
            k++;
        end
        while (busy !== 1'b0 && k < 300) begin
            step(1);
            k++;
        end
        step(2);
        check(busy, 1'b0);
        check_cfg(lv);
    endtask : run_scan
    task automatic sync_pulse();
        sync_n = 1'b0;
        mask = rnd[27:24];
        step(1);
        check(st, {14'h0, ~mask});
        sync_n = 1'b1;
        step(1);
        check(align, 1'b1);
        step(1);
        check(st, 4'h0);
    endtask : sync_pulse
    task automatic spi_write(input logic [7:0] o, input logic [7:0] v);
        wr = 1'b1;
        offs = o;
        data = v;
        step(1);
        wr = 1'b0;
        step(1);
    endtask : spi_write
    task automatic tally_and_finish();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        step(12);
        i_reset_n = 1'b1;
        run_scan(straps);
        old = straps;
        rnd = roll(rnd);
        straps = rnd[17:0];
        step(60);
        check_cfg(old);
        for (int i = 0; i < 14; i++) begin
            rnd = roll(rnd);
            straps = (i < 8) ? {6{i[2:0]}} : rnd[17:0];
            term = rnd[21:18];
            slow = rnd[22];
            sync_pulse();
            run_scan(straps);
        end
        mode = 1'b0;
        step(2);
        check({p_spi, p_i2c, multi, smode, ph_en, dr_en}, 6'h2B);
        d = rnd[7:0];
        spi_write(8'h00, d);
        check(cfg, d);
        spi_write(8'h01, ~d);
        check(cfg, d);
        sync_pulse();
        step(8);
        check(busy, 1'b0);
        straps = ~straps;
        mode = 1'b1;
        spi_write(8'h00, ~d);
        check(cfg, d);
        run_scan(straps);
        check({p_i2c, smode}, 2'h3);
        tally_and_finish();
    end
endmodule : strap_config_and_port_select_tb_top
